// ### hdl/ilm_lane.sv
/*
 * One byte lane of a level register: two 3-bit level fields.
 * Assumes a one-cycle write strobe already decoded for this lane.
 */
`timescale 1ns/1ns
`include "ilm_regs.svh"

module ilm_lane (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                wr_en,
    input  wire logic [7:0]          wdata,
    output ilm_pkg::ilm_level_t      lo_level,
    output ilm_pkg::ilm_level_t      hi_level,
    output logic [7:0]               rdata
);
    import ilm_pkg::*;

    wire ilm_level_t next_lo = wdata[`ILM_LO_LSB +: 3];
    wire ilm_level_t next_hi = wdata[`ILM_HI_LSB +: 3];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lo_level <= `ILM_LEVEL_RST;
            hi_level <= `ILM_LEVEL_RST;
        end else if (wr_en) begin
            lo_level <= next_lo;
            hi_level <= next_hi;
        end
    end

    assign rdata = ilm_lane_image(hi_level, lo_level);

endmodule

// ### hdl/ilm_prio_enc.sv
/*
 * Combinational priority encoder over the mapped sources.
 * Assumes pending and enable inputs are synchronous to the clock.
 */
`timescale 1ns/1ns
`include "ilm_regs.svh"

module ilm_prio_enc (
    input  ilm_pkg::ilm_level_t [`ILM_NUM_SRC-1:0] levels,
    input  wire logic [`ILM_NUM_SRC-1:0]           pending,
    input  wire logic [`ILM_NUM_SRC-1:0]           enable,
    output ilm_pkg::ilm_level_t                    best_level,
    output logic [3:0]                             best_source
);
    import ilm_pkg::*;

    always_comb begin
        best_level  = `ILM_LEVEL_RST;
        best_source = 4'h0;
        for (int i = 0; i < `ILM_NUM_SRC; i++) begin
            // Strict compare: lowest index wins a tie
            if (pending[i] && enable[i] && (levels[i] > best_level)) begin
                best_level  = levels[i];
                best_source = 4'(i);
            end
        end
    end

endmodule

// ### hdl/ilm_top.sv
/*
 * Interrupt level mapping registers of the local bus interrupter:
 * level fields for signal, location monitor, software and backplane
 * IRQ7 sources, and the priority encoder toward the local processor.
 * Assumes a plain register port synchronous to CLK_SYS, with read
 * data returned in the cycle after the read strobe.
 */
// The implementer's own choice: the strobed register port.
// Notes on behaviour
// [R01] Second level register bits 15..8 hold the signal zero and one levels, read/write.
// [R02] Second level register bits 7..0 hold the location monitor zero and one levels.
// [R03] Third level register bits 31..24 hold software interrupt six and seven levels.
// [R04] Third level register bits 23..16 hold software interrupt four and five levels.
// [R05] Third level register bits 15..8 hold software interrupt two and three levels.
// [R06] Third level register bits 7..0 hold software interrupt zero and one levels.
// [R07] Fourth level register bits 31..24 route backplane IRQ7 to any local level.
// [R08] The spare field beside the IRQ7 field is storage only and drives no source.
// [R09] Each lane uses six of eight bits as two 3-bit fields; the rest read zero.
// [R10] All fields clear on reset, and level zero keeps its source from interrupting.
// [R11] Each field but the spare feeds the priority encoder, which asserts the chosen level one to seven.
`timescale 1ns/1ns
`include "ilm_regs.svh"

module ilm_top (
    input  wire logic                    CLK_SYS,
    input  wire logic                    ARST_N,
    input  wire logic [31:0]             REG_ADDR,
    input  wire logic [31:0]             REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic [31:0]                  REG_RDATA,
    input  wire logic [`ILM_NUM_SRC-1:0] SRC_PENDING,
    input  wire logic [`ILM_NUM_SRC-1:0] SRC_ENABLE,
    output ilm_pkg::ilm_level_t          SIGNAL_ZERO_PRIORITY,
    output ilm_pkg::ilm_level_t          SIGNAL_ONE_PRIORITY,
    output ilm_pkg::ilm_level_t          LOCATION_MONITOR_ZERO_PRIORITY,
    output ilm_pkg::ilm_level_t          LOCATION_MONITOR_ONE_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_ZERO_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_ONE_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_TWO_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_THREE_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_FOUR_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_FIVE_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_SIX_PRIORITY,
    output ilm_pkg::ilm_level_t          SOFT_IRQ_SEVEN_PRIORITY,
    output ilm_pkg::ilm_level_t          BACKPLANE_IRQ_SEVEN_PRIORITY,
    output ilm_pkg::ilm_level_t          IRQ_LEVEL,
    output logic [3:0]                   IRQ_SOURCE,
    output logic                         IRQ_REQUEST
);
    import ilm_pkg::*;

    // ------------------------------------------------------------
    // Register select
    // ------------------------------------------------------------
    wire logic hit_two   = ilm_hit(REG_ADDR, `ILM_LEVEL_MAP_TWO_ADDR);
    wire logic hit_three = ilm_hit(REG_ADDR, `ILM_LEVEL_MAP_THREE_ADDR);
    wire logic hit_four  = ilm_hit(REG_ADDR, `ILM_LEVEL_MAP_FOUR_ADDR);

    wire logic wr_two    = REG_WR && hit_two;
    wire logic wr_three  = REG_WR && hit_three;
    wire logic wr_four   = REG_WR && hit_four;

    // ------------------------------------------------------------
    // Level fields
    // ------------------------------------------------------------
    ilm_level_t lm0_lvl;
    ilm_level_t lm1_lvl;
    ilm_level_t sig0_lvl;
    ilm_level_t sig1_lvl;
    ilm_level_t sw_lvl [8];
    ilm_level_t virq7_lvl;
    ilm_level_t spare_lvl;

    logic [7:0] two_lane0;
    logic [7:0] two_lane1;
    logic [7:0] three_lane0;
    logic [7:0] three_lane1;
    logic [7:0] three_lane2;
    logic [7:0] three_lane3;
    logic [7:0] four_lane3;

    // [R02] location monitor lane
    ilm_lane u_two_lane0 (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .wr_en    (wr_two),
        .wdata    (REG_WDATA[`ILM_LANE0_LSB +: 8]),
        .lo_level (lm0_lvl),
        .hi_level (lm1_lvl),
        .rdata    (two_lane0)
    );

    // [R01] signal level lane
    ilm_lane u_two_lane1 (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .wr_en    (wr_two),
        .wdata    (REG_WDATA[`ILM_LANE1_LSB +: 8]),
        .lo_level (sig0_lvl),
        .hi_level (sig1_lvl),
        .rdata    (two_lane1)
    );

    // [R06] software zero/one lane
    ilm_lane u_three_lane0 (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .wr_en    (wr_three),
        .wdata    (REG_WDATA[`ILM_LANE0_LSB +: 8]),
        .lo_level (sw_lvl[0]),
        .hi_level (sw_lvl[1]),
        .rdata    (three_lane0)
    );

    // [R05] software two/three lane
    ilm_lane u_three_lane1 (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .wr_en    (wr_three),
        .wdata    (REG_WDATA[`ILM_LANE1_LSB +: 8]),
        .lo_level (sw_lvl[2]),
        .hi_level (sw_lvl[3]),
        .rdata    (three_lane1)
    );

    // [R04] software four/five lane
    ilm_lane u_three_lane2 (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .wr_en    (wr_three),
        .wdata    (REG_WDATA[`ILM_LANE2_LSB +: 8]),
        .lo_level (sw_lvl[4]),
        .hi_level (sw_lvl[5]),
        .rdata    (three_lane2)
    );

    // [R03] software six/seven lane
    ilm_lane u_three_lane3 (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .wr_en    (wr_three),
        .wdata    (REG_WDATA[`ILM_LANE3_LSB +: 8]),
        .lo_level (sw_lvl[6]),
        .hi_level (sw_lvl[7]),
        .rdata    (three_lane3)
    );

    // [R07] backplane IRQ7 lane, spare in upper field
    // [R08] spare field kept for readback only
    ilm_lane u_four_lane3 (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .wr_en    (wr_four),
        .wdata    (REG_WDATA[`ILM_LANE3_LSB +: 8]),
        .lo_level (virq7_lvl),
        .hi_level (spare_lvl),
        .rdata    (four_lane3)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Lanes owned by other level sources read as zero here
    // [R09] unused lane bits zero
    wire logic [31:0] img_two   = {16'h0000, two_lane1, two_lane0};
    wire logic [31:0] img_three = {three_lane3, three_lane2, three_lane1, three_lane0};
    wire logic [31:0] img_four  = {four_lane3, 24'h00_0000};

    wire logic [31:0] rd_sel = hit_two   ? img_two   :
                               hit_three ? img_three :
                               hit_four  ? img_four  : `ILM_RDATA_RST;

    // Data stands only in the cycle after the strobe
    wire logic [31:0] next_rdata = REG_RD ? rd_sel : `ILM_RDATA_RST;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= `ILM_RDATA_RST;
        end else begin
            REG_RDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Per-source level outputs
    // ------------------------------------------------------------
    assign SIGNAL_ZERO_PRIORITY           = sig0_lvl;
    assign SIGNAL_ONE_PRIORITY            = sig1_lvl;
    assign LOCATION_MONITOR_ZERO_PRIORITY = lm0_lvl;
    assign LOCATION_MONITOR_ONE_PRIORITY  = lm1_lvl;
    assign SOFT_IRQ_ZERO_PRIORITY         = sw_lvl[0];
    assign SOFT_IRQ_ONE_PRIORITY          = sw_lvl[1];
    assign SOFT_IRQ_TWO_PRIORITY          = sw_lvl[2];
    assign SOFT_IRQ_THREE_PRIORITY        = sw_lvl[3];
    assign SOFT_IRQ_FOUR_PRIORITY         = sw_lvl[4];
    assign SOFT_IRQ_FIVE_PRIORITY         = sw_lvl[5];
    assign SOFT_IRQ_SIX_PRIORITY          = sw_lvl[6];
    assign SOFT_IRQ_SEVEN_PRIORITY        = sw_lvl[7];
    assign BACKPLANE_IRQ_SEVEN_PRIORITY   = virq7_lvl;

    // ------------------------------------------------------------
    // Priority encoding
    // ------------------------------------------------------------
    ilm_level_t [`ILM_NUM_SRC-1:0] src_levels;

    // [R11] fields into encoder
    assign src_levels[ILM_SRC_SIG0]  = sig0_lvl;
    assign src_levels[ILM_SRC_SIG1]  = sig1_lvl;
    assign src_levels[ILM_SRC_LM0]   = lm0_lvl;
    assign src_levels[ILM_SRC_LM1]   = lm1_lvl;
    assign src_levels[ILM_SRC_SW0]   = sw_lvl[0];
    assign src_levels[ILM_SRC_SW1]   = sw_lvl[1];
    assign src_levels[ILM_SRC_SW2]   = sw_lvl[2];
    assign src_levels[ILM_SRC_SW3]   = sw_lvl[3];
    assign src_levels[ILM_SRC_SW4]   = sw_lvl[4];
    assign src_levels[ILM_SRC_SW5]   = sw_lvl[5];
    assign src_levels[ILM_SRC_SW6]   = sw_lvl[6];
    assign src_levels[ILM_SRC_SW7]   = sw_lvl[7];
    assign src_levels[ILM_SRC_VIRQ7] = virq7_lvl;

    ilm_level_t enc_level;
    logic [3:0] enc_source;

    ilm_prio_enc u_enc (
        .levels      (src_levels),
        .pending     (SRC_PENDING),
        .enable      (SRC_ENABLE),
        .best_level  (enc_level),
        .best_source (enc_source)
    );

    // [R10] level zero never requests
    wire logic next_request = (enc_level != `ILM_LEVEL_RST);

    // Registered so the processor sees a glitch-free level
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ_LEVEL   <= `ILM_LEVEL_RST;
            IRQ_SOURCE  <= 4'h0;
            IRQ_REQUEST <= 1'b0;
        end else begin
            IRQ_LEVEL   <= enc_level;
            IRQ_SOURCE  <= enc_source;
            IRQ_REQUEST <= next_request;
        end
    end

endmodule

// ### pkg/ilm_pkg.sv
/*
 * Types and helpers shared by the interrupt level mapping block.
 * Assumes ilm_regs.svh on the include path.
 */
`include "ilm_regs.svh"

package ilm_pkg;

    typedef logic [2:0] ilm_level_t;

    // Source index order of the priority encoder
    typedef enum logic [3:0] {
        ILM_SRC_SIG0  = 4'h0,
        ILM_SRC_SIG1  = 4'h1,
        ILM_SRC_LM0   = 4'h2,
        ILM_SRC_LM1   = 4'h3,
        ILM_SRC_SW0   = 4'h4,
        ILM_SRC_SW1   = 4'h5,
        ILM_SRC_SW2   = 4'h6,
        ILM_SRC_SW3   = 4'h7,
        ILM_SRC_SW4   = 4'h8,
        ILM_SRC_SW5   = 4'h9,
        ILM_SRC_SW6   = 4'hA,
        ILM_SRC_SW7   = 4'hB,
        ILM_SRC_VIRQ7 = 4'hC
    } ilm_src_t;

    // Lane image: unused bits 7 and 3 read as zero
    function automatic logic [7:0] ilm_lane_image(input ilm_level_t hi, input ilm_level_t lo);
        ilm_lane_image = {1'b0, hi, 1'b0, lo};
    endfunction

    // Address compare used by every register select
    function automatic logic ilm_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        ilm_hit = (addr == reg_addr);
    endfunction

endpackage

// ### pkg/ilm_regs.svh
/*
 * Register map, field positions and reset values of the interrupt
 * level mapping block.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef ILM_REGS_SVH
`define ILM_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ILM_LEVEL_MAP_TWO_ADDR   32'hFFF4007C
`define ILM_LEVEL_MAP_THREE_ADDR 32'hFFF40080
`define ILM_LEVEL_MAP_FOUR_ADDR  32'hFFF40084

// ----------------------------------------------------------------
// Byte lanes and fields inside a lane
// ----------------------------------------------------------------
`define ILM_LANE0_LSB 0
`define ILM_LANE1_LSB 8
`define ILM_LANE2_LSB 16
`define ILM_LANE3_LSB 24
`define ILM_LO_LSB    0
`define ILM_HI_LSB    4

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define ILM_LEVEL_RST 3'h0
`define ILM_RDATA_RST 32'h0000_0000
`define ILM_NUM_SRC   13

`endif

// ### verification/ilm_cpu_model.sv
/*
 * Local processor model: takes the level while a request stands.
 * Assumes registered encoder outputs on the same clock.
 */
`timescale 1ns/1ns

module ilm_cpu_model (
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  ilm_pkg::ilm_level_t irq_level,
    input  wire logic           irq_request,
    output ilm_pkg::ilm_level_t taken_level
);
    import ilm_pkg::*;
    // Holds the last level served, so a dropped request is still visible
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            taken_level <= 3'h0;
        end else if (irq_request) begin
            taken_level <= irq_level;
        end
    end
endmodule

// ### verification/ilm_top_asserts.sv
/*
 * Checker for the level mapping registers and encoder outputs.
 * Assumes it is bound to ilm_top and sees only its ports.
 */
`timescale 1ns/1ns
`include "ilm_regs.svh"

module ilm_top_asserts
    import ilm_pkg::*;
(
    input  wire logic           CLK_SYS,
    input  wire logic           ARST_N,
    input  wire logic [31:0]    REG_ADDR,
    input  wire logic [31:0]    REG_WDATA,
    input  wire logic           REG_WR,
    input  wire logic           REG_RD,
    input  wire logic [31:0]    REG_RDATA,
    input  wire logic [12:0]    SRC_PENDING,
    input  wire logic [12:0]    SRC_ENABLE,
    input  ilm_pkg::ilm_level_t SIGNAL_ZERO_PRIORITY,
    input  ilm_pkg::ilm_level_t SIGNAL_ONE_PRIORITY,
    input  ilm_pkg::ilm_level_t LOCATION_MONITOR_ZERO_PRIORITY,
    input  ilm_pkg::ilm_level_t LOCATION_MONITOR_ONE_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_ZERO_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_ONE_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_TWO_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_THREE_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_FOUR_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_FIVE_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_SIX_PRIORITY,
    input  ilm_pkg::ilm_level_t SOFT_IRQ_SEVEN_PRIORITY,
    input  ilm_pkg::ilm_level_t BACKPLANE_IRQ_SEVEN_PRIORITY,
    input  ilm_pkg::ilm_level_t IRQ_LEVEL,
    input  wire logic [3:0]     IRQ_SOURCE,
    input  wire logic           IRQ_REQUEST
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // Previous-cycle live sources, matching the registered encoder
    logic [12:0] live;
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            live <= 13'h0000;
        end else begin
            live <= SRC_PENDING & SRC_ENABLE;
        end
    end
    wire h2 = REG_ADDR == `ILM_LEVEL_MAP_TWO_ADDR;
    wire h3 = REG_ADDR == `ILM_LEVEL_MAP_THREE_ADDR;
    wire h4 = REG_ADDR == `ILM_LEVEL_MAP_FOUR_ADDR;
    wire [31:0] i2 = {17'h0, SIGNAL_ONE_PRIORITY, 1'b0, SIGNAL_ZERO_PRIORITY, 1'b0,
        LOCATION_MONITOR_ONE_PRIORITY, 1'b0, LOCATION_MONITOR_ZERO_PRIORITY};
    wire [31:0] i3 = {1'b0, SOFT_IRQ_SEVEN_PRIORITY, 1'b0, SOFT_IRQ_SIX_PRIORITY,
        1'b0, SOFT_IRQ_FIVE_PRIORITY, 1'b0, SOFT_IRQ_FOUR_PRIORITY,
        1'b0, SOFT_IRQ_THREE_PRIORITY, 1'b0, SOFT_IRQ_TWO_PRIORITY,
        1'b0, SOFT_IRQ_ONE_PRIORITY, 1'b0, SOFT_IRQ_ZERO_PRIORITY};
    wire [31:0] i4 = {5'h00, BACKPLANE_IRQ_SEVEN_PRIORITY, 24'h000000};
    sequence wr2_s; REG_WR && h2; endsequence
    sequence wr3_s; REG_WR && h3; endsequence
    sequence wr4_s; REG_WR && h4; endsequence
    chk_sig_lm_write: assert property (
        wr2_s |=> i2 == ($past(REG_WDATA) & 32'h00007777)) else $error("reg two write");
    chk_sw_write: assert property (
        wr3_s |=> i3 == ($past(REG_WDATA) & 32'h77777777)) else $error("reg three write");
    chk_irq7_write: assert property (
        wr4_s |=> i4 == ($past(REG_WDATA) & 32'h07000000)) else $error("reg four write");
    chk_reg2_readback: assert property (
        REG_RD && h2 |=> REG_RDATA == $past(i2)) else $error("reg two read");
    chk_reg3_readback: assert property (
        REG_RD && h3 |=> REG_RDATA == $past(i3)) else $error("reg three read");
    chk_reg4_readback: assert property (
        REG_RD && h4 |=> (REG_RDATA & 32'h87FFFFFF) == $past(i4)) else $error("reg four read");
    chk_rdata_idle: assert property (
        !$past(REG_RD) |-> REG_RDATA == 32'h00000000) else $error("read data not idle");
    chk_fields_hold: assert property (
        !(REG_WR && (h2 || h3 || h4)) |=> $stable({i2, i3, i4})) else $error("field moved");
    chk_req_level: assert property (
        IRQ_REQUEST == (IRQ_LEVEL != 3'h0)) else $error("request and level differ");
    chk_src_live: assert property (
        IRQ_REQUEST |-> live[IRQ_SOURCE]) else $error("source not live");
    chk_quiet_none: assert property (
        live == 13'h0000 |-> !IRQ_REQUEST) else $error("request with no source");
endmodule

bind ilm_top ilm_top_asserts u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .SRC_PENDING(SRC_PENDING), .SRC_ENABLE(SRC_ENABLE),
    .SIGNAL_ZERO_PRIORITY(SIGNAL_ZERO_PRIORITY), .SIGNAL_ONE_PRIORITY(SIGNAL_ONE_PRIORITY),
    .LOCATION_MONITOR_ZERO_PRIORITY(LOCATION_MONITOR_ZERO_PRIORITY),
    .LOCATION_MONITOR_ONE_PRIORITY(LOCATION_MONITOR_ONE_PRIORITY),
    .SOFT_IRQ_ZERO_PRIORITY(SOFT_IRQ_ZERO_PRIORITY), .SOFT_IRQ_ONE_PRIORITY(SOFT_IRQ_ONE_PRIORITY),
    .SOFT_IRQ_TWO_PRIORITY(SOFT_IRQ_TWO_PRIORITY),
    .SOFT_IRQ_THREE_PRIORITY(SOFT_IRQ_THREE_PRIORITY),
    .SOFT_IRQ_FOUR_PRIORITY(SOFT_IRQ_FOUR_PRIORITY),
    .SOFT_IRQ_FIVE_PRIORITY(SOFT_IRQ_FIVE_PRIORITY),
    .SOFT_IRQ_SIX_PRIORITY(SOFT_IRQ_SIX_PRIORITY),
    .SOFT_IRQ_SEVEN_PRIORITY(SOFT_IRQ_SEVEN_PRIORITY),
    .BACKPLANE_IRQ_SEVEN_PRIORITY(BACKPLANE_IRQ_SEVEN_PRIORITY), .IRQ_LEVEL(IRQ_LEVEL),
    .IRQ_SOURCE(IRQ_SOURCE), .IRQ_REQUEST(IRQ_REQUEST));

// ### verification/ilm_top_tb.sv
/*
 * Self-checking bench for the level mapping block.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ns
`include "ilm_regs.svh"

module ilm_top_tb;
    import ilm_pkg::*;
    localparam logic [31:0] A2 = `ILM_LEVEL_MAP_TWO_ADDR;
    localparam logic [31:0] A3 = `ILM_LEVEL_MAP_THREE_ADDR;
    localparam logic [31:0] A4 = `ILM_LEVEL_MAP_FOUR_ADDR;
    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic [31:0] addr    = 32'h00000000;
    logic [31:0] wdata   = 32'h00000000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [12:0] pend    = 13'h0000;
    logic [12:0] ena     = 13'h0000;
    logic [31:0] rdata;
    ilm_level_t  f [13];
    ilm_level_t  lvl;
    ilm_level_t  cpu_lvl;
    logic [3:0]  src;
    logic        req;
    int          n_mismatch = 0;
    int          compares   = 0;

    always #10 clk_sys = ~clk_sys;

    ilm_top uut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SRC_PENDING(pend), .SRC_ENABLE(ena),
        .SIGNAL_ZERO_PRIORITY(f[0]), .SIGNAL_ONE_PRIORITY(f[1]),
        .LOCATION_MONITOR_ZERO_PRIORITY(f[2]), .LOCATION_MONITOR_ONE_PRIORITY(f[3]),
        .SOFT_IRQ_ZERO_PRIORITY(f[4]), .SOFT_IRQ_ONE_PRIORITY(f[5]),
        .SOFT_IRQ_TWO_PRIORITY(f[6]), .SOFT_IRQ_THREE_PRIORITY(f[7]),
        .SOFT_IRQ_FOUR_PRIORITY(f[8]), .SOFT_IRQ_FIVE_PRIORITY(f[9]),
        .SOFT_IRQ_SIX_PRIORITY(f[10]), .SOFT_IRQ_SEVEN_PRIORITY(f[11]),
        .BACKPLANE_IRQ_SEVEN_PRIORITY(f[12]), .IRQ_LEVEL(lvl), .IRQ_SOURCE(src),
        .IRQ_REQUEST(req));
    ilm_cpu_model cpu (.clk(clk_sys), .arst_n(arst_n), .irq_level(lvl),
        .irq_request(req), .taken_level(cpu_lvl));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, rdata);
    endtask
    task automatic irq(input logic [12:0] p, input logic [12:0] e, input ilm_level_t el,
                       input logic [3:0] es);
        @(posedge clk_sys);
        pend <= p;
        ena  <= e;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq level", {29'h0, el}, {29'h0, lvl});
        chk("irq source", {28'h0, es}, {28'h0, src});
        chk("irq request", {31'h0, el != 3'h0}, {31'h0, req});
        if (el != 3'h0) chk("cpu level", {29'h0, el}, {29'h0, cpu_lvl});
    endtask

    task automatic t_reset;
        for (int i = 0; i < 13; i++) begin
            chk($sformatf("field %0d", i), 32'h0, {29'h0, f[i]});
        end
        chk("request at reset", 32'h0, {31'h0, req});
        rd_chk(A2, 32'h00000000);
        rd_chk(A3, 32'h00000000);
        rd_chk(A4, 32'h00000000);
        $display("test reset done");
    endtask
    task automatic t_regs;
        wr_reg(A2, 32'hFFFFFFFF);
        rd_chk(A2, 32'h00007777);
        wr_reg(A2, 32'h00003521);
        chk("sig zero", 32'h5, {29'h0, f[0]});
        chk("sig one", 32'h3, {29'h0, f[1]});
        chk("lm zero", 32'h1, {29'h0, f[2]});
        chk("lm one", 32'h2, {29'h0, f[3]});
        wr_reg(A3, 32'hFFFFFFFF);
        rd_chk(A3, 32'h77777777);
        wr_reg(A3, 32'h76543210);
        for (int i = 0; i < 8; i++) begin
            chk($sformatf("soft %0d", i), i, {29'h0, f[4 + i]});
        end
        rd_chk(A3, 32'h76543210);
        wr_reg(A4, 32'hFFFFFFFF);
        rd_chk(A4, 32'h77000000);
        wr_reg(A4, 32'h35000000);
        chk("irq7", 32'h5, {29'h0, f[12]});
        wr_reg(32'hFFF40088, 32'hFFFFFFFF);
        rd_chk(A4, 32'h35000000);
        rd_chk(32'hFFF40088, 32'h00000000);
        $display("test registers done");
    endtask
    task automatic t_encoder;
        wr_reg(A2, 32'h00003300);
        wr_reg(A4, 32'h71000000);
        irq(13'h1FFF, 13'h1FFF, 3'h7, 4'hB);
        irq(13'h1FFF, 13'h17FF, 3'h6, 4'hA);
        irq(13'h0010, 13'h1FFF, 3'h0, 4'h0);
        irq(13'h0003, 13'h1FFF, 3'h3, 4'h0);
        irq(13'h1000, 13'h1FFF, 3'h1, 4'hC);
        irq(13'h1FFF, 13'h0000, 3'h0, 4'h0);
        $display("test encoder done");
    endtask
    task automatic t_mid_reset;
        // Request standing when reset hits, so its drop is seen
        irq(13'h1FFF, 13'h1FFF, 3'h7, 4'hB);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(A2, 32'h00000000);
        rd_chk(A3, 32'h00000000);
        rd_chk(A4, 32'h00000000);
        chk("soft seven after reset", 32'h0, {29'h0, f[11]});
        chk("level after reset", 32'h0, {29'h0, lvl});
        chk("source after reset", 32'h0, {28'h0, src});
        chk("request after reset", 32'h0, {31'h0, req});
        chk("cpu level after reset", 32'h0, {29'h0, cpu_lvl});
        $display("test mid reset done");
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset;
        t_regs;
        t_encoder;
        t_mid_reset;
        end_sim;
    end
    // Whole run is about seventy cycles; this allows ample slack
    initial begin
        #100000;
        n_mismatch++;
        end_sim;
    end
endmodule
